// ===== rtl/hpsc_pkg.sv
// hub power and string configuration bank: shared constants and types
// assumes a byte-wide configuration port clocked by the hub core clock
package hpsc_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] HPSC_OFS_BUS_MAX_POWER = 8'h0D;
    localparam logic [7:0] HPSC_OFS_CTRL_CUR_SELF = 8'h0E;
    localparam logic [7:0] HPSC_OFS_CTRL_CUR_BUS = 8'h0F;
    localparam logic [7:0] HPSC_OFS_POWER_GOOD = 8'h10;
    localparam logic [7:0] HPSC_OFS_LANG_UPPER = 8'h11;
    localparam logic [7:0] HPSC_OFS_LANG_LOWER = 8'h12;
    localparam logic [7:0] HPSC_OFS_MAKER_LEN = 8'h13;
    localparam logic [7:0] HPSC_OFS_PRODUCT_LEN = 8'h14;
    localparam logic [7:0] HPSC_OFS_SERIAL_LEN = 8'h15;
    localparam int HPSC_REG_COUNT = 9;

    // index of each register inside the bank
    localparam logic [3:0] HPSC_IDX_BUS_MAX_POWER = 4'h0;
    localparam logic [3:0] HPSC_IDX_CTRL_CUR_SELF = 4'h1;
    localparam logic [3:0] HPSC_IDX_CTRL_CUR_BUS = 4'h2;
    localparam logic [3:0] HPSC_IDX_POWER_GOOD = 4'h3;
    localparam logic [3:0] HPSC_IDX_LANG_UPPER = 4'h4;
    localparam logic [3:0] HPSC_IDX_LANG_LOWER = 4'h5;
    localparam logic [3:0] HPSC_IDX_MAKER_LEN = 4'h6;
    localparam logic [3:0] HPSC_IDX_PRODUCT_LEN = 4'h7;
    localparam logic [3:0] HPSC_IDX_SERIAL_LEN = 4'h8;

    // ****************************************
    // reset values and limits
    // ****************************************
    localparam logic [7:0] HPSC_RST_ZERO = 8'h00;
    localparam logic [7:0] HPSC_RST_CTRL_CURRENT = 8'h32;
    localparam logic [7:0] HPSC_CTRL_CURRENT_LIMIT = 8'h32;
    localparam logic [7:0] HPSC_UNMAPPED_READ = 8'h00;
    localparam logic [7:0] HPSC_TEXT_MAX_CHARS = 8'h1F;
    localparam logic [5:0] HPSC_TEXT_MAX_BYTES = 6'h3E;
    localparam int HPSC_TEXT_COUNT = 3;

    typedef logic [HPSC_REG_COUNT-1:0][7:0] hpsc_regs_t;

    function automatic logic hpsc_reg_hit(input logic [7:0] addr);
        return (addr >= HPSC_OFS_BUS_MAX_POWER) &&
               (addr <= HPSC_OFS_SERIAL_LEN);
    endfunction

    function automatic logic [3:0] hpsc_reg_index(input logic [7:0] addr);
        logic [7:0] diff;
        diff = addr - HPSC_OFS_BUS_MAX_POWER;
        return diff[3:0];
    endfunction

endpackage

// ===== rtl/hpsc_desc_if.sv
// carrier between the register bank and the descriptor field calculator
// assumes both ends sit in the hub core clock domain
`timescale 1ns/10ps
interface hpsc_desc_if;
    import hpsc_pkg::*;
    logic [7:0] ctrlCurSelf;
    logic [7:0] ctrlCurBus;
    logic [7:0] langUpper;
    logic [7:0] langLower;
    logic [HPSC_TEXT_COUNT-1:0][7:0] textLen;
    logic [8:0] selfMa;
    logic [8:0] busMa;
    logic [15:0] langId;
    logic [HPSC_TEXT_COUNT-1:0][5:0] textBytes;
    logic [HPSC_TEXT_COUNT-1:0] textTooLong;
    logic selfOverLimit;

    modport bank (
        output ctrlCurSelf, ctrlCurBus, langUpper, langLower, textLen,
        input selfMa, busMa, langId, textBytes, textTooLong, selfOverLimit
    );
    modport calc (
        input ctrlCurSelf, ctrlCurBus, langUpper, langLower, textLen,
        output selfMa, busMa, langId, textBytes, textTooLong, selfOverLimit
    );
endinterface

// ===== rtl/hpsc_desc_calc.sv
// descriptor field calculator: turns raw bytes into reported values
// assumes stable register values from the bank; purely combinational
`timescale 1ns/10ps
module hpsc_desc_calc
    import hpsc_pkg::*;
(
    // register values in, descriptor fields out
    hpsc_desc_if.calc desc
);

    // ****************************************
    // current in milliamps, two per step
    // ****************************************
    assign desc.selfMa = {desc.ctrlCurSelf, 1'b0};
    assign desc.busMa = {desc.ctrlCurBus, 1'b0};
    assign desc.selfOverLimit =
        desc.ctrlCurSelf > HPSC_CTRL_CURRENT_LIMIT;

    // upper byte on top
    assign desc.langId = {desc.langUpper, desc.langLower};

    // ****************************************
    // string byte counts, two bytes per character
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < HPSC_TEXT_COUNT; i++)
        begin : g_text
            assign desc.textTooLong[i] =
                desc.textLen[i] > HPSC_TEXT_MAX_CHARS;
            assign desc.textBytes[i] = desc.textTooLong[i] ?
                HPSC_TEXT_MAX_BYTES : {desc.textLen[i][4:0], 1'b0};
        end
    endgenerate

endmodule // hpsc_desc_calc

// ===== rtl/hpsc_config_bank.sv
// hub power and string configuration bank, offsets 0x0D to 0x15
// assumes the configuration port is driven by logic on ref_clk
`timescale 1ns/10ps
module hpsc_config_bank
    import hpsc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // configuration port
    input wire logic [7:0] cfgAddr,
    input wire logic cfgWrite,
    input wire logic [7:0] cfgWrData,
    input wire logic cfgRead,
    output logic [7:0] cfgRdData,
    output logic cfgRdValid,
    // raw fields reported in descriptors
    output logic [7:0] busMaxPower,
    output logic [7:0] portPowerGoodDelay,
    // derived descriptor fields
    output logic [8:0] selfCtrlCurrentMa,
    output logic [8:0] busCtrlCurrentMa,
    output logic [15:0] languageId,
    output logic [5:0] makerTextBytes,
    output logic [5:0] productTextBytes,
    output logic [5:0] serialTextBytes,
    // configuration checks
    output logic [2:0] textTooLong,
    output logic selfCurrentOverLimit
);
    import hpsc_pkg::*;

    // every check samples on the core clock
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    typedef struct packed {
        hpsc_regs_t regs;
        logic [7:0] rdData;
        logic rdValid;
        logic [8:0] selfMa;
        logic [8:0] busMa;
        logic [15:0] langId;
        logic [HPSC_TEXT_COUNT-1:0][5:0] textBytes;
        logic [HPSC_TEXT_COUNT-1:0] textTooLong;
        logic selfOverLimit;
    } hpsc_bank_state_t;

    hpsc_bank_state_t state_q;
    hpsc_bank_state_t state_d;
    hpsc_desc_if desc ();

    // ****************************************
    // descriptor field calculator
    // ****************************************
    assign desc.ctrlCurSelf = state_q.regs[HPSC_IDX_CTRL_CUR_SELF];
    assign desc.ctrlCurBus = state_q.regs[HPSC_IDX_CTRL_CUR_BUS];
    assign desc.langUpper = state_q.regs[HPSC_IDX_LANG_UPPER];
    assign desc.langLower = state_q.regs[HPSC_IDX_LANG_LOWER];
    assign desc.textLen[0] = state_q.regs[HPSC_IDX_MAKER_LEN];
    assign desc.textLen[1] = state_q.regs[HPSC_IDX_PRODUCT_LEN];
    assign desc.textLen[2] = state_q.regs[HPSC_IDX_SERIAL_LEN];

    hpsc_desc_calc u_calc (
        .desc (desc.calc)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        state_d = state_q;
        // plain storage, a write changes only the addressed byte
        if (cfgWrite && hpsc_reg_hit(cfgAddr))
        begin
            state_d.regs[hpsc_reg_index(cfgAddr)] = cfgWrData;
        end
        state_d.rdValid = cfgRead;
        if (cfgRead)
        begin
            state_d.rdData = hpsc_reg_hit(cfgAddr) ?
                state_q.regs[hpsc_reg_index(cfgAddr)] :
                HPSC_UNMAPPED_READ;
        end
        state_d.selfMa = desc.selfMa;
        state_d.busMa = desc.busMa;
        state_d.selfOverLimit = desc.selfOverLimit;
        state_d.langId = desc.langId;
        state_d.textBytes = desc.textBytes;
        state_d.textTooLong = desc.textTooLong;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= '0;
            state_q.regs[HPSC_IDX_CTRL_CUR_SELF] <=
                HPSC_RST_CTRL_CURRENT;
            state_q.regs[HPSC_IDX_CTRL_CUR_BUS] <=
                HPSC_RST_CTRL_CURRENT;
            state_q.selfMa <= {HPSC_RST_CTRL_CURRENT, 1'b0};
            state_q.busMa <= {HPSC_RST_CTRL_CURRENT, 1'b0};
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign cfgRdData = state_q.rdData;
    assign cfgRdValid = state_q.rdValid;
    assign busMaxPower = state_q.regs[HPSC_IDX_BUS_MAX_POWER];
    assign portPowerGoodDelay = state_q.regs[HPSC_IDX_POWER_GOOD];
    assign selfCtrlCurrentMa = state_q.selfMa;
    assign busCtrlCurrentMa = state_q.busMa;
    assign languageId = state_q.langId;
    assign makerTextBytes = state_q.textBytes[0];
    assign productTextBytes = state_q.textBytes[1];
    assign serialTextBytes = state_q.textBytes[2];
    assign textTooLong = state_q.textTooLong;
    assign selfCurrentOverLimit = state_q.selfOverLimit;

    // ****************************************
    // assertions
    // ****************************************
    property p_bus_max_power;
        cfgWrite && cfgAddr == HPSC_OFS_BUS_MAX_POWER |=>
            busMaxPower == $past(cfgWrData);
    endproperty
    a_bus_max_power: assert property (p_bus_max_power)
        else $error("bus max power byte not stored");

    property p_self_ma;
        cfgWrite && cfgAddr == HPSC_OFS_CTRL_CUR_SELF |=>
            ##1 selfCtrlCurrentMa == {$past(cfgWrData, 2), 1'b0};
    endproperty
    a_self_ma: assert property (p_self_ma)
        else $error("self-powered current not twice the code");

    property p_self_limit;
        ##1 selfCurrentOverLimit ==
            ($past(desc.ctrlCurSelf) > HPSC_CTRL_CURRENT_LIMIT);
    endproperty
    a_self_limit: assert property (p_self_limit)
        else $error("over-limit flag wrong");

    property p_bus_ma;
        ##1 busCtrlCurrentMa == {$past(desc.ctrlCurBus), 1'b0};
    endproperty
    a_bus_ma: assert property (p_bus_ma)
        else $error("bus-powered current not twice the code");

    property p_power_good;
        cfgWrite && cfgAddr == HPSC_OFS_POWER_GOOD |=>
            portPowerGoodDelay == $past(cfgWrData);
    endproperty
    a_power_good: assert property (p_power_good)
        else $error("power-good delay not stored");

    property p_lang_upper;
        cfgWrite && cfgAddr == HPSC_OFS_LANG_UPPER |=>
            ##1 languageId[15:8] == $past(cfgWrData, 2);
    endproperty
    a_lang_upper: assert property (p_lang_upper)
        else $error("language upper byte misplaced");

    property p_lang_lower;
        cfgWrite && cfgAddr == HPSC_OFS_LANG_LOWER |=>
            ##1 languageId[7:0] == $past(cfgWrData, 2);
    endproperty
    a_lang_lower: assert property (p_lang_lower)
        else $error("language lower byte misplaced");

    property p_text_clamp;
        textTooLong[0] |-> makerTextBytes == HPSC_TEXT_MAX_BYTES;
    endproperty
    a_text_clamp: assert property (p_text_clamp)
        else $error("long maker text not clamped");

    property p_text_flag;
        ##1 textTooLong[1] ==
            ($past(desc.textLen[1]) > HPSC_TEXT_MAX_CHARS);
    endproperty
    a_text_flag: assert property (p_text_flag)
        else $error("product text length flag wrong");

    property p_text_bytes;
        ##1 !textTooLong[2] |->
            serialTextBytes == {$past(desc.textLen[2][4:0]), 1'b0};
    endproperty
    a_text_bytes: assert property (p_text_bytes)
        else $error("serial text byte count wrong");

    property p_unmapped_read;
        cfgRead && !hpsc_reg_hit(cfgAddr) |=>
            cfgRdValid && cfgRdData == HPSC_UNMAPPED_READ;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read not zero");

    property p_read_idle;
        !cfgRead |=> !cfgRdValid && $stable(cfgRdData);
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("read answer without a read");

    c_write_read: cover property (cfgWrite ##1 cfgRead ##1 cfgRdValid);
    c_over_limit: cover property ($rose(selfCurrentOverLimit));
    c_text_long: cover property ($rose(textTooLong[1]));
    c_unmapped_read: cover property (cfgRead && !hpsc_reg_hit(cfgAddr));

endmodule // hpsc_config_bank

// ===== dv/hpsc_host_model.sv
// configuring party model: drives the byte-wide configuration port
// assumes the bank samples its port at the ref_clk rising edge
`timescale 1ns/10ps
module hpsc_host_model
(
    // clock
    input wire logic ref_clk,
    // configuration port
    output logic [7:0] cfgAddr,
    output logic cfgWrite,
    output logic [7:0] cfgWrData,
    output logic cfgRead,
    input wire logic [7:0] cfgRdData,
    input wire logic cfgRdValid
);
    // ****************************************
    // bus cycles
    // ****************************************
    initial
    begin
        cfgAddr = 8'h00;
        cfgWrite = 1'b0;
        cfgWrData = 8'h00;
        cfgRead = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        cfgAddr <= a;
        cfgWrData <= d;
        cfgWrite <= 1'b1;
        @(posedge ref_clk);
        cfgWrite <= 1'b0;
        // released data must not keep the last value
        cfgWrData <= ~d;
    endtask

    // legal setup: self-powered current capped at code 0x32, lengths at 31
    task automatic wrLegal(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if ((a == 8'h0E) && (d > 8'h32))
            v = 8'h32;
        if ((a >= 8'h13) && (a <= 8'h15) && (d > 8'h1F))
            v = 8'h1F;
        wr(a, v);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic ok);
        @(posedge ref_clk);
        cfgAddr <= a;
        cfgRead <= 1'b1;
        @(posedge ref_clk);
        cfgRead <= 1'b0;
        #1;
        ok = cfgRdValid;
        d = cfgRdData;
    endtask
endmodule // hpsc_host_model

// ===== dv/tb_hpsc_config_bank.sv
// self-checking bench for the hub power and string configuration bank
// assumes a 100 MHz ref_clk and the host model on the config port
`timescale 1ns/10ps
module tb_hpsc_config_bank;
    import hpsc_pkg::*;
    // ****************************************
    // wiring
    // ****************************************
    logic ref_clk, rst_n, cfgWrite, cfgRead, cfgRdValid;
    logic selfCurrentOverLimit;
    logic [7:0] cfgAddr, cfgWrData, cfgRdData, busMaxPower;
    logic [7:0] portPowerGoodDelay;
    logic [8:0] selfCtrlCurrentMa, busCtrlCurrentMa;
    logic [15:0] languageId;
    logic [5:0] makerTextBytes, productTextBytes, serialTextBytes;
    logic [2:0] textTooLong;
    int miscompares = 0;
    int compares = 0;

    hpsc_config_bank dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .cfgAddr(cfgAddr), .cfgWrite(cfgWrite), .cfgWrData(cfgWrData),
        .cfgRead(cfgRead), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
        .busMaxPower(busMaxPower), .portPowerGoodDelay(portPowerGoodDelay),
        .selfCtrlCurrentMa(selfCtrlCurrentMa),
        .busCtrlCurrentMa(busCtrlCurrentMa), .languageId(languageId),
        .makerTextBytes(makerTextBytes),
        .productTextBytes(productTextBytes),
        .serialTextBytes(serialTextBytes), .textTooLong(textTooLong),
        .selfCurrentOverLimit(selfCurrentOverLimit));
    hpsc_host_model host (.ref_clk(ref_clk), .cfgAddr(cfgAddr),
        .cfgWrite(cfgWrite), .cfgWrData(cfgWrData), .cfgRead(cfgRead),
        .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid));

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host.rd(a, d, ok);
        chk({15'h0000, ok}, 16'h0001);
        chk({8'h00, d}, {8'h00, exp});
    endtask

    // derived fields land one edge after the register
    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    task automatic conclude();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if ((miscompares == 0) && (compares > 0))
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        logic [7:0] a;
        chk({7'h00, selfCtrlCurrentMa}, 16'h0064);
        chk({7'h00, busCtrlCurrentMa}, 16'h0064);
        for (int i = 0; i < 11; i++)
        begin
            a = 8'h0C + 8'(i);
            rdChk(a, ((a == 8'h0E) || (a == 8'h0F)) ? 8'h32 : 8'h00);
        end
    endtask

    task automatic t_store();
        logic [7:0] ev;
        for (int i = 0; i < 9; i++)
            host.wr(8'h0D + 8'(i), 8'hA0 + 8'(i));
        host.wr(8'h0C, 8'h55);
        host.wr(8'h16, 8'h55);
        settle();
        chk({8'h00, busMaxPower}, 16'h00A0);
        chk({8'h00, portPowerGoodDelay}, 16'h00A3);
        chk(languageId, 16'hA4A5);
        chk({15'h0000, selfCurrentOverLimit}, 16'h0001);
        for (int i = 0; i < 11; i++)
        begin
            ev = ((i == 0) || (i == 10)) ? 8'h00 : 8'h9F + 8'(i);
            rdChk(8'h0C + 8'(i), ev);
        end
    endtask

    task automatic t_current();
        logic [7:0] codes[4] = '{8'h00, 8'h32, 8'h33, 8'hFF};
        logic over;
        foreach (codes[i])
        begin
            host.wr(8'h0E, codes[i]);
            host.wr(8'h0F, ~codes[i]);
            settle();
            chk({7'h00, selfCtrlCurrentMa}, {7'h00, codes[i], 1'b0});
            chk({7'h00, busCtrlCurrentMa}, {7'h00, ~codes[i], 1'b0});
            over = codes[i] > 8'h32;
            chk({15'h0000, selfCurrentOverLimit}, {15'h0000, over});
        end
        host.wrLegal(8'h0E, 8'hFF);
        settle();
        chk({7'h00, selfCtrlCurrentMa}, 16'h0064);
    endtask

    task automatic t_text();
        logic [7:0] lens[5] = '{8'h00, 8'h01, 8'h1F, 8'h20, 8'hFF};
        logic [5:0] eb;
        logic [5:0] got;
        logic exTl;
        foreach (lens[i])
        begin
            host.wr(8'h13, lens[i]);
            host.wr(8'h14, lens[(i + 1) % 5]);
            host.wr(8'h15, lens[(i + 2) % 5]);
            settle();
            for (int k = 0; k < 3; k++)
            begin
                exTl = lens[(i + k) % 5] > 8'h1F;
                eb = exTl ? 6'h3E : {lens[(i + k) % 5][4:0], 1'b0};
                got = (k == 0) ? makerTextBytes :
                      (k == 1) ? productTextBytes : serialTextBytes;
                chk({10'h000, got}, {10'h000, eb});
                chk({15'h0000, textTooLong[k]}, {15'h0000, exTl});
            end
        end
    endtask

    task automatic t_lang();
        host.wr(8'h11, 8'h04);
        host.wr(8'h12, 8'h09);
        settle();
        chk(languageId, 16'h0409);
        host.wr(8'h12, 8'h07);
        settle();
        chk(languageId, 16'h0407);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial
    begin
        #200000;
        miscompares++;
        conclude();
    end

    initial
    begin
        rst_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        t_reset();
        t_store();
        t_current();
        t_text();
        t_lang();
        conclude();
    end
endmodule // tb_hpsc_config_bank
